// >>> shared/acfc_defines.svh
// Offsets, field positions, reset values and timing counts for the conversion flow control
`ifndef ACFC_DEFINES_SVH
`define ACFC_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ACFC_OFS_CTRL      12'h000
`define ACFC_OFS_FLOW      12'h004
`define ACFC_OFS_STATUS    12'h008
`define ACFC_OFS_RESULT    12'h00c
`define ACFC_OFS_ORDER     12'h010

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define ACFC_CTRL_ACC_HI   11
`define ACFC_CTRL_ACC_LO   10
`define ACFC_CTRL_STORE    9
`define ACFC_CTRL_MODE     8
`define ACFC_CTRL_DBL_CMD  1
`define ACFC_CTRL_DBL_RES  0
`define ACFC_CTRL_RESET    16'h0000
`define ACFC_CTRL_MASK     16'h0f03

// ----------------------------------------
// Flow request bits
// ----------------------------------------
`define ACFC_FLW_ABORT     3
`define ACFC_FLW_TRIGGER_REQUEST      2
`define ACFC_FLW_RESTART   1
`define ACFC_FLW_SWAP      0

// ----------------------------------------
// Timing
// ----------------------------------------
`define ACFC_CONV_CYCLES   8'h10
`define ACFC_LIST_LEN      3'h4

`endif

// >>> shared/acfc_pkg.sv
// Types for the conversion flow control
`default_nettype none
package acfc_pkg;
    typedef enum logic [1:0] {
        ACFC_ACC_NONE,
        ACFC_ACC_INTERNAL,
        ACFC_ACC_BUS,
        ACFC_ACC_BOTH
    } acfc_access_t;

    typedef enum {
        ACFC_IDLE,
        ACFC_ARMED,
        ACFC_CONVERT,
        ACFC_ABORTING
    } acfc_state_t;
endpackage
`default_nettype wire

// >>> shared/acfc_if.sv
// Internal flow control interface between trigger logic and the converter
`timescale 1ns/1ps
`default_nettype none
interface acfc_if (
    input wire logic pclk,    // Bus clock
    input wire logic presetn  // Async reset, low
);
    logic       req_valid;    // Internal write strobe
    logic [3:0] req_set;      // Flow bits to set
    logic [3:0] flow_bits;    // Current flow bits
    logic       busy;         // Conversion or sequence ongoing
    logic       restart_err;  // Restart error flag

    modport device (input req_valid, req_set, output flow_bits, busy, restart_err);
    modport trigger_request   (output req_valid, req_set, input flow_bits, busy, restart_err);
endinterface
`default_nettype wire

// >>> hw/acfc_device.sv
// Converter end: control word, flow requests, sequence engine and APB slave
//
// Contract
// R1 - Access field picks bus, internal or both
// R2 - Access field resets to zero, no path
// R3 - Store off: aborted conversion discarded, no flag
// R4 - Store off: early lone restart flags error, sets abort
// R5 - Store on: aborted conversion stored, flags updated
// R6 - Store on: lone restart raises no error
// R7 - Mode bit: 0 restart mode, 1 trigger
// R8 - Four request bits: abort, trigger, restart, swap
// R9 - Single or double buffering per list
// R10 - Controller fills a command list before start
// R11 - Restart plus trigger starts first list
// R12 - Swap with restart starts second list
// R13 - Restart only while converter idle
// R14 - Abort stops sequence, cleared when idle
// R15 - Restart must follow abort before trigger
// R16 - Restart done: clear, accept trigger, list top
// R17 - Writes over disabled path ignored
`timescale 1ns/1ps
`default_nettype none
`include "acfc_defines.svh"
module acfc_device import acfc_pkg::*; (
    input  wire logic        pclk,      // Bus clock
    input  wire logic        presetn,   // Async reset, low
    input  wire logic        psel,      // APB select
    input  wire logic        penable,   // APB enable
    input  wire logic        pwrite,    // APB direction
    input  wire logic [11:0] paddr,     // APB address
    input  wire logic [31:0] pwdata,    // APB write data
    output logic      [31:0] prdata,    // APB read data
    output logic             pready,    // APB ready
    output logic             pslverr,   // APB error
    acfc_if.device           flw        // Internal flow interface
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [15:0] ctrl_q;
    logic [3:0]  flow_q, flow_d;
    logic        err_q;
    logic [7:0]  cnt_q;
    logic [2:0]  idx_q;
    logic        list_q;
    logic        rlist_q;
    logic [15:0] result_q;
    logic [7:0]  done_q;
    acfc_state_t state_q;
    logic        busy_q;

    wire logic       acc_wr  = psel & penable & pwrite;
    wire logic       bus_ok  = ctrl_q[`ACFC_CTRL_ACC_HI];
    wire logic       int_ok  = ctrl_q[`ACFC_CTRL_ACC_LO];
    wire logic       store   = ctrl_q[`ACFC_CTRL_STORE];
    wire logic       trigmd  = ctrl_q[`ACFC_CTRL_MODE];
    wire logic       last    = (idx_q == `ACFC_LIST_LEN - 3'h1);
    wire logic       conv    = (state_q == ACFC_CONVERT);
    wire logic       bus_fw  = acc_wr & (paddr == `ACFC_OFS_FLOW) & bus_ok;   // see R1 see R17
    wire logic       int_fw  = flw.req_valid & int_ok;                        // see R1 see R17
    wire logic [3:0] set_req = (bus_fw ? pwdata[3:0] : 4'h0) | (int_fw ? flw.req_set : 4'h0);
    wire logic       rst_ev  = set_req[`ACFC_FLW_RESTART];
    wire logic       abt_ev  = set_req[`ACFC_FLW_ABORT];
    wire logic       trg_ev  = set_req[`ACFC_FLW_TRIGGER_REQUEST] | flow_q[`ACFC_FLW_TRIGGER_REQUEST];
    wire logic       lone    = rst_ev & ~abt_ev & ~flow_q[`ACFC_FLW_ABORT];
    wire logic       early   = conv & lone & ~store & ~(last && cnt_q == 8'h01);
    wire logic       cut     = conv & (rst_ev | abt_ev);

    // ----------------------------------------
    // Control word
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `ACFC_CTRL_RESET;                                       // see R2
        end else if (acc_wr && paddr == `ACFC_OFS_CTRL) begin
            ctrl_q <= pwdata[15:0] & `ACFC_CTRL_MASK;                         // see R7 see R9
        end
    end

    // ----------------------------------------
    // Flow request bits
    // ----------------------------------------
    always_comb begin
        flow_d = flow_q | set_req;                                            // see R8
        if (early) begin
            flow_d[`ACFC_FLW_ABORT] = 1'b1;                                   // see R4
        end
        // Abort clears only once the engine is idle again
        if (state_q == ACFC_ABORTING) begin
            flow_d[`ACFC_FLW_ABORT] = 1'b0;                                   // see R14
        end
        // Restart completes in one cycle when idle
        if (flow_q[`ACFC_FLW_RESTART] && !busy_q && !flow_q[`ACFC_FLW_ABORT]) begin
            flow_d[`ACFC_FLW_RESTART] = 1'b0;                                 // see R16
            flow_d[`ACFC_FLW_SWAP]    = 1'b0;
        end
        if (state_q == ACFC_ARMED && trg_ev) begin
            flow_d[`ACFC_FLW_TRIGGER_REQUEST] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flow_q <= 4'h0;
        end else begin
            flow_q <= flow_d;
        end
    end

    // ----------------------------------------
    // Restart error flag, set wins over clear
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
        end else if (early) begin
            err_q <= 1'b1;                                                    // see R4 see R6
        end else if (acc_wr && paddr == `ACFC_OFS_STATUS && pwdata[0]) begin
            err_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Sequence engine
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ACFC_IDLE;
            cnt_q   <= 8'h00;
            idx_q   <= 3'h0;
            list_q  <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            case (state_q)
                ACFC_IDLE: begin
                    busy_q <= 1'b0;
                    if (flow_q[`ACFC_FLW_ABORT]) begin
                        state_q <= ACFC_ABORTING;
                    end else if (flow_q[`ACFC_FLW_RESTART]) begin
                        idx_q   <= 3'h0;                                      // see R11 see R16
                        state_q <= ACFC_ARMED;
                        if (flow_q[`ACFC_FLW_SWAP] && ctrl_q[`ACFC_CTRL_DBL_CMD]) begin
                            list_q <= ~list_q;                                // see R12
                        end
                    end
                end
                ACFC_ARMED: begin
                    if (flow_q[`ACFC_FLW_ABORT]) begin
                        state_q <= ACFC_ABORTING;
                    end else if (trg_ev) begin
                        state_q <= ACFC_CONVERT;
                        cnt_q   <= `ACFC_CONV_CYCLES;
                        busy_q  <= 1'b1;
                    end
                end
                ACFC_CONVERT: begin
                    if (cut || flow_q[`ACFC_FLW_ABORT]) begin
                        state_q <= ACFC_ABORTING;                             // see R14
                    end else if (cnt_q == 8'h01) begin
                        cnt_q <= `ACFC_CONV_CYCLES;
                        idx_q <= idx_q + 3'h1;
                        if (last) begin
                            idx_q <= 3'h0;
                            // End of list: trigger mode waits, restart mode goes idle
                            state_q <= trigmd ? ACFC_ARMED : ACFC_IDLE;       // see R7
                            busy_q  <= 1'b0;
                        end
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ACFC_ABORTING: begin
                    busy_q  <= 1'b0;
                    idx_q   <= 3'h0;
                    state_q <= ACFC_IDLE;
                end
                default: begin
                    state_q <= ACFC_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Result storage
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= 16'h0000;
            done_q   <= 8'h00;
            rlist_q  <= 1'b0;
        end else begin
            // Clear goes first so a completion in the same cycle still lands
            if (acc_wr && paddr == `ACFC_OFS_RESULT) begin
                done_q <= done_q & ~pwdata[7:0];
            end
            if (conv && ((cnt_q == 8'h01 && !cut) || (cut && store))) begin   // see R3 see R5
                result_q             <= {list_q, rlist_q, 11'h000, idx_q};
                done_q[{rlist_q, idx_q[1:0]}] <= 1'b1;
                if (last && ctrl_q[`ACFC_CTRL_DBL_RES]) begin
                    rlist_q <= ~rlist_q;                                      // see R9
                end
            end
        end
    end

    // ----------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    `ACFC_OFS_CTRL:   prdata <= {16'h0000, ctrl_q};
                    `ACFC_OFS_FLOW:   prdata <= {28'h0000000, flow_q};
                    `ACFC_OFS_STATUS: prdata <= {24'h000000, busy_q, list_q, 5'h00, err_q};
                    `ACFC_OFS_RESULT: prdata <= {8'h00, done_q, result_q};
                    default:          pslverr <= 1'b1;
                endcase
            end
        end
    end

    assign flw.flow_bits   = flow_q;
    assign flw.busy        = busy_q;
    assign flw.restart_err = err_q;
endmodule
`default_nettype wire

// >>> hw/acfc_trigger.sv
// Trigger end: turns user strobes into internal flow requests in legal order
`timescale 1ns/1ps
`default_nettype none
`include "acfc_defines.svh"
module acfc_trigger import acfc_pkg::*; (
    input  wire logic       pclk,       // Bus clock
    input  wire logic       presetn,    // Async reset, low
    input  wire logic       start,      // Pulse: restart then trigger
    input  wire logic       use_second, // Start from other list
    input  wire logic       abort,      // Pulse: abort sequence
    input  wire logic       trigger,    // Pulse: trigger only
    output logic            ready,      // Idle, may accept start
    output logic            error,      // Restart error seen
    acfc_if.trigger_request            flw         // Internal flow interface
);
    // ----------------------------------------
    // Request sequencer
    // ----------------------------------------
    typedef enum {ACFC_T_IDLE, ACFC_T_ABORT, ACFC_T_RST, ACFC_T_TRIGGER_REQUEST} acfc_tstate_t;
    acfc_tstate_t st_q;
    logic         swap_q;
    logic         rerun_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q          <= ACFC_T_IDLE;
            swap_q        <= 1'b0;
            rerun_q       <= 1'b0;
            flw.req_valid <= 1'b0;
            flw.req_set   <= 4'h0;
            ready         <= 1'b0;
            error         <= 1'b0;
        end else begin
            flw.req_valid <= 1'b0;
            flw.req_set   <= 4'h0;
            error         <= flw.restart_err;
            ready         <= (st_q == ACFC_T_IDLE) & ~flw.busy & (flw.flow_bits == 4'h0);
            case (st_q)
                ACFC_T_IDLE: begin
                    if (abort) begin
                        flw.req_valid <= 1'b1;
                        flw.req_set   <= 4'b1000;
                        st_q          <= ACFC_T_ABORT;
                        rerun_q       <= 1'b0;
                    end else if (start) begin
                        swap_q  <= use_second;
                        rerun_q <= 1'b1;
                        // Restart only from idle, else abort first
                        st_q   <= flw.busy ? ACFC_T_ABORT : ACFC_T_RST;      // see R13
                        if (flw.busy) begin
                            flw.req_valid <= 1'b1;
                            flw.req_set   <= 4'b1000;
                        end
                    end else if (trigger) begin
                        flw.req_valid <= 1'b1;
                        flw.req_set   <= 4'b0100;
                    end
                end
                ACFC_T_ABORT: begin
                    if (!flw.flow_bits[`ACFC_FLW_ABORT] && !flw.req_valid) begin
                        // A bare abort parks in idle; only a start reruns the list
                        st_q <= rerun_q ? ACFC_T_RST : ACFC_T_IDLE;           // see R15
                    end
                end
                ACFC_T_RST: begin
                    if (!flw.busy) begin
                        flw.req_valid <= 1'b1;
                        flw.req_set   <= {2'b00, 1'b1, swap_q};               // see R11 see R12
                        st_q          <= ACFC_T_TRIGGER_REQUEST;
                    end
                end
                ACFC_T_TRIGGER_REQUEST: begin
                    if (!flw.req_valid && !flw.flow_bits[`ACFC_FLW_RESTART]) begin
                        flw.req_valid <= 1'b1;
                        flw.req_set   <= 4'b0100;                             // see R16
                        st_q          <= ACFC_T_IDLE;
                    end
                end
                default: begin
                    st_q <= ACFC_T_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> sim/acfc_chk.sv
// Interface checker for the conversion flow control link
`timescale 1ns/1ps
`default_nettype none
`include "acfc_defines.svh"
module acfc_chk (
    input wire logic       pclk,        // Bus clock
    input wire logic       presetn,     // Async reset, low
    input wire logic       req_valid,   // Internal write strobe
    input wire logic [3:0] req_set,     // Flow bits to set
    input wire logic [3:0] flow_bits,   // Current flow bits
    input wire logic       busy,        // Conversion ongoing
    input wire logic       restart_err  // Restart error flag
);
    // ----------------------------------------
    // Sequences and assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_restart_done;
        $fell(flow_bits[1]);
    endsequence
    sequence s_abort_done;
        $fell(flow_bits[3]);
    endsequence
    // Busy that ends with no abort or restart request behind it
    sequence s_busy_ends_clean;
        $fell(busy) && !$past(flow_bits[3]) && !$past(flow_bits[1]);
    endsequence

    // Saturating run length of busy; a cut conversion is exempt above
    logic [7:0] busy_run;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_run <= 8'h00;
        end else if (!busy) begin
            busy_run <= 8'h00;
        end else if (busy_run != 8'hff) begin
            busy_run <= busy_run + 8'h01;
        end
    end

    chk_reset_clean: assert property ($rose(presetn) |-> flow_bits == 4'h0 && !busy && !restart_err)
        else $error("flow bits or flags not clear after reset");
    chk_restart_ends: assert property ($rose(flow_bits[1]) |-> ##[1:200] !flow_bits[1])
        else $error("restart request never cleared");
    chk_restart_idle: assert property (s_restart_done |-> !busy)
        else $error("restart cleared while converting");
    chk_abort_ends: assert property ($rose(flow_bits[3]) |-> ##[1:200] !flow_bits[3])
        else $error("abort request never cleared");
    chk_abort_idle: assert property (s_abort_done |-> !busy ##1 !busy)
        else $error("abort cleared before converter idle");
    chk_err_abort: assert property ($rose(restart_err) |-> ##[0:2] flow_bits[3])
        else $error("restart error without abort set");
    chk_conv_len: assert property (s_busy_ends_clean |-> busy_run >= `ACFC_CONV_CYCLES)
        else $error("conversion ended too soon");
    chk_req_pulse: assert property (req_valid |=> !req_valid)
        else $error("internal request longer than one cycle");
    chk_req_nonzero: assert property (req_valid |-> req_set != 4'h0)
        else $error("internal request with no bits");
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Testbench: both ends joined, APB and trigger strobes driven
`timescale 1ns/1ps
`default_nettype none
`include "acfc_defines.svh"
module tb import acfc_pkg::*; ;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic        start, use_second, abort, trigger, ready, error;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          errors, n_tests, k;

    acfc_if u_if (.pclk(pclk), .presetn(presetn));
    acfc_device u_acfc_device (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flw(u_if));
    acfc_trigger u_acfc_trigger (.pclk(pclk), .presetn(presetn), .start(start), .use_second(use_second),
        .abort(abort), .trigger(trigger), .ready(ready), .error(error), .flw(u_if));
    acfc_chk u_acfc_chk (.pclk(pclk), .presetn(presetn), .req_valid(u_if.req_valid), .req_set(u_if.req_set),
        .flow_bits(u_if.flow_bits), .busy(u_if.busy), .restart_err(u_if.restart_err));

    always #2.5 pclk = ~pclk;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Bounded wait so a stuck bit cannot hang the run
    // Looks at falling edges, where a bit set on the last rising edge has settled
    task wait_clr(input int b);
        k = 0;
        @(negedge pclk);
        while (u_if.flow_bits[b] !== 1'b0 && k < 300) begin
            @(negedge pclk);
            k++;
        end
        chk("flow_clear", 32'h0, {31'h0, u_if.flow_bits[b]});
    endtask

    task go();
        apb(1'b1, `ACFC_OFS_FLOW, 32'h2);
        wait_clr(1);
        apb(1'b1, `ACFC_OFS_FLOW, 32'h4);
    endtask

    task finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        finish_test();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000; pwdata = 32'h0;
        start = 0; use_second = 0; abort = 0; trigger = 0; errors = 0; n_tests = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `ACFC_OFS_CTRL, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        apb(1'b1, `ACFC_OFS_FLOW, 32'hf);
        repeat (2) @(posedge pclk);
        chk("flow_no_path", 32'h0, {28'h0, u_if.flow_bits});
        apb(1'b0, 12'hffc, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, se});
        $display("test reset done");
        apb(1'b1, `ACFC_OFS_CTRL, 32'h400);
        apb(1'b1, `ACFC_OFS_FLOW, 32'h2);
        repeat (2) @(posedge pclk);
        chk("bus_blocked", 32'h0, {28'h0, u_if.flow_bits});
        apb(1'b1, `ACFC_OFS_CTRL, 32'h800);
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("internal_blocked", 32'h0, {27'h0, u_if.busy, u_if.flow_bits});
        $display("test access path done");
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, `ACFC_OFS_CTRL, 32'h800 | (m << 8));
            apb(1'b1, `ACFC_OFS_RESULT, 32'h000000ff);
            go();
            repeat (3) @(posedge pclk);
            chk("busy_after_start", 32'h1, {31'h0, u_if.busy});
            k = 0;
            while (u_if.busy !== 1'b0 && k < 300) begin
                @(posedge pclk);
                k++;
            end
            apb(1'b0, `ACFC_OFS_RESULT, 32'h0);
            chk("list_done", 32'h0f, {24'h0, rd[23:16]});
        end
        $display("test bus start done");
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, `ACFC_OFS_CTRL, 32'h800 | (s << 9));
            apb(1'b1, `ACFC_OFS_RESULT, 32'h000000ff);
            go();
            repeat (20) @(posedge pclk);
            apb(1'b1, `ACFC_OFS_FLOW, 32'h8);
            wait_clr(3);
            chk("idle_after_abort", 32'h0, {31'h0, u_if.busy});
            apb(1'b0, `ACFC_OFS_RESULT, 32'h0);
            chk("abort_store", s ? 32'h03 : 32'h01, {24'h0, rd[23:16]});
        end
        $display("test abort storage done");
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, `ACFC_OFS_CTRL, 32'hc00 | (s << 9));
            apb(1'b1, `ACFC_OFS_STATUS, 32'h1);
            go();
            repeat (20) @(posedge pclk);
            apb(1'b1, `ACFC_OFS_FLOW, 32'h2);
            repeat (4) @(posedge pclk);
            apb(1'b0, `ACFC_OFS_STATUS, 32'h0);
            chk("restart_err", s ? 32'h0 : 32'h1, {31'h0, rd[0]});
            chk("trigger_request_err_copy", s ? 32'h0 : 32'h1, {31'h0, error});
            apb(1'b1, `ACFC_OFS_FLOW, 32'h8);
            wait_clr(3);
            wait_clr(1);
            apb(1'b1, `ACFC_OFS_STATUS, 32'h1);
        end
        $display("test lone restart done");
        apb(1'b1, `ACFC_OFS_CTRL, 32'h402);
        use_second <= 1'b1;
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        k = 0;
        while (u_if.busy !== 1'b1 && k < 100) begin
            @(posedge pclk);
            k++;
        end
        chk("internal_start", 32'h1, {31'h0, u_if.busy});
        apb(1'b0, `ACFC_OFS_STATUS, 32'h0);
        chk("second_list", 32'h1, {31'h0, rd[6]});
        abort <= 1'b1;
        @(posedge pclk);
        abort <= 1'b0;
        repeat (3) @(posedge pclk);
        wait_clr(3);
        repeat (3) @(posedge pclk);
        chk("ready_after_abort", 32'h1, {31'h0, ready});
        // Trigger mode: list end waits armed, a lone trigger pulse reruns it
        apb(1'b1, `ACFC_OFS_CTRL, 32'h500);
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        repeat (8) @(posedge pclk);
        k = 0;
        while (u_if.busy !== 1'b0 && k < 300) begin
            @(posedge pclk);
            k++;
        end
        trigger <= 1'b1;
        @(posedge pclk);
        trigger <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("trigger_rerun", 32'h1, {31'h0, u_if.busy});
        $display("test internal path done");
        finish_test();
    end
endmodule
`default_nettype wire
